// ==== verilog/pcwg_regs.vh ====
/*
 Offsets, field positions and reset values for the configuration write guard.
 Assumes it is included by bare name from the design files.
*/
`ifndef PCWG_REGS_VH
`define PCWG_REGS_VH

// ----------------------------------------------------------------
// Local address map (byte addresses on the internal bus)
// ----------------------------------------------------------------
`define PCWG_PCI_STATUS_WORD_ADDR 32'hFFFED006
`define PCWG_CLASS_CODE_BYTE_ADDR 32'hFFFED008
`define PCWG_SUBCLASS_CODE_BYTE_ADDR 32'hFFFED009
`define PCWG_REVISION_BYTE_ADDR 32'hFFFED00B
`define PCWG_SUBSYSTEM_VENDOR_WORD_ADDR 32'hFFFED02C
`define PCWG_SUBSYSTEM_IDENT_WORD_ADDR 32'hFFFED02E
`define PCWG_MAX_LATENCY_BYTE_ADDR 32'hFFFED03C
`define PCWG_MIN_GRANT_BYTE_ADDR 32'hFFFED03D
`define PCWG_INTERRUPT_PIN_BYTE_ADDR 32'hFFFED03E
`define PCWG_CFG_BASE 32'hFFFED000

// ----------------------------------------------------------------
// Configuration dword indices holding guarded fields
// ----------------------------------------------------------------
`define PCWG_DW_STATUS 6'h01
`define PCWG_DW_CLASS 6'h02
`define PCWG_DW_SUBSYS 6'h0B
`define PCWG_DW_LATGNT 6'h0F

// ----------------------------------------------------------------
// Bits owned by this block in each dword (local-write-only)
// ----------------------------------------------------------------
`define PCWG_FAST_B2B_CAPABLE_BIT 23
`define PCWG_USER_FEATURE_CAPABLE_BIT 22
`define PCWG_MASK_STATUS 32'h00C00000
`define PCWG_MASK_CLASS 32'hFF00FFFF
`define PCWG_MASK_SUBSYS 32'hFFFFFFFF
`define PCWG_MASK_LATGNT 32'h00FFFFFF
`define PCWG_MASK_NONE 32'h00000000

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PCWG_RST_STATUS 32'h00000000
`define PCWG_RST_CLASS 32'h00000000
`define PCWG_RST_SUBSYS 32'h00000000
`define PCWG_RST_LATGNT 32'h00000000

`endif

// ==== verilog/pcwg_cfg_word.v ====
/*
 One guarded configuration dword with per-lane write merging.
 Assumes both write ports are on the same clock and reset already synchronised.
*/
`timescale 1ns/1ns
`include "pcwg_regs.vh"

module pcwg_cfg_word #(
	parameter [31:0] LOCAL_MASK = 32'hFFFFFFFF,
	parameter [31:0] PCI_MASK = 32'h00000000,
	parameter [31:0] RESET_VAL = 32'h00000000
) (
	// Clock and reset
	input wire clk_in,
	input wire rst_b_in,
	// Local CPU write
	input wire loc_wr_in,
	input wire [3:0] loc_be_in,
	input wire [31:0] loc_wdata_in,
	// External configuration write
	input wire pci_wr_in,
	input wire [3:0] pci_be_in,
	input wire [31:0] pci_wdata_in,
	// Stored value
	output wire [31:0] word_out
);

	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			// One register per lane keeps a single driver per flip-flop
			reg [7:0] byte_q;
			wire [7:0] lmask;
			wire [7:0] pmask;
			wire [7:0] loc_sel;
			wire [7:0] pci_sel;
			assign lmask = LOCAL_MASK[lane*8 +: 8];
			// Guarded bits are masked out of PCI_MASK, so external data cannot reach them
			assign pmask = PCI_MASK[lane*8 +: 8] & ~lmask; // RQ1
			assign loc_sel = (loc_wr_in && loc_be_in[lane]) ? lmask : 8'h00; // RQ6
			assign pci_sel = (pci_wr_in && pci_be_in[lane]) ? pmask : 8'h00;
			assign word_out[lane*8 +: 8] = byte_q;
			always @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					byte_q <= RESET_VAL[lane*8 +: 8];
				end else begin
					// Separate masks per source: a coinciding external write cannot latch
					byte_q <= (byte_q & ~(loc_sel | pci_sel))
						| (loc_wdata_in[lane*8 +: 8] & loc_sel)
						| (pci_wdata_in[lane*8 +: 8] & pci_sel); // RQ4
				end
			end
		end
	endgenerate

endmodule

// ==== verilog/pcwg_guard.v ====
/*
 Local-write-only guard for configuration header fields of the PCI controller in
 target mode. Local CPU writes by byte address; external masters use dword index.
 Assumes the PCI target front end delivers decoded configuration cycles on
 ref_clk_in; non-guarded configuration bits live elsewhere and read here as zero.
*/
`timescale 1ns/1ns
`include "pcwg_regs.vh"

// How it works
// RQ1 - External config writes leave guarded bits unchanged
// RQ2 - Status capability bits guarded from external writes
// RQ3 - Class, revision, subsystem, latency, grant, pin guarded
// RQ4 - Guard holds during concurrent local CPU writes
// RQ5 - External master should read-modify-write guarded words
// RQ6 - Local CPU writes update; external reads allowed
module pcwg_guard (
	// Clock and reset
	input wire ref_clk_in,
	input wire rst_b_in,
	// Local CPU access, byte addressed
	input wire loc_wr_in,
	input wire loc_rd_in,
	input wire [31:0] loc_addr_in,
	input wire [3:0] loc_be_in,
	input wire [31:0] loc_wdata_in,
	output wire loc_ack_out,
	output wire [31:0] loc_rdata_out,
	// External configuration access, dword indexed
	input wire cfg_wr_in,
	input wire cfg_rd_in,
	input wire [5:0] cfg_dw_in,
	input wire [3:0] cfg_be_in,
	input wire [31:0] cfg_wdata_in,
	output wire cfg_ack_out,
	output wire [31:0] cfg_rdata_out,
	// Guarded field values for the controller
	output wire fast_back_to_back_capable_out,
	output wire user_feature_capable_out,
	output wire [23:0] class_code_out,
	output wire [7:0] revision_out,
	output wire [15:0] subsystem_vendor_out,
	output wire [15:0] subsystem_ident_out,
	output wire [7:0] max_latency_out,
	output wire [7:0] min_grant_out,
	output wire [7:0] interrupt_pin_out
);

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	reg rst_meta_q;
	reg rst_sync_q;

	always @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Dword index to one-hot word select; used for both access ports
	function [3:0] dw_sel;
		input [5:0] dw;
		begin
			if (dw == `PCWG_DW_STATUS) begin
				dw_sel = 4'h1;
			end else if (dw == `PCWG_DW_CLASS) begin
				dw_sel = 4'h2;
			end else if (dw == `PCWG_DW_SUBSYS) begin
				dw_sel = 4'h4;
			end else if (dw == `PCWG_DW_LATGNT) begin
				dw_sel = 4'h8;
			end else begin
				dw_sel = 4'h0;
			end
		end
	endfunction

	wire loc_in_win;
	wire [5:0] loc_dw;
	wire [3:0] loc_sel;
	wire [3:0] cfg_sel;

	assign loc_in_win = ({loc_addr_in[31:8], 8'h00} == `PCWG_CFG_BASE);
	assign loc_dw = loc_addr_in[7:2];
	assign loc_sel = loc_in_win ? dw_sel(loc_dw) : 4'h0;
	assign cfg_sel = dw_sel(cfg_dw_in);

	// ----------------------------------------------------------------
	// Guarded words
	// ----------------------------------------------------------------
	// Parameter overrides need constants, so the tables are localparams
	localparam [127:0] LMASK_ALL = {`PCWG_MASK_LATGNT, `PCWG_MASK_SUBSYS, `PCWG_MASK_CLASS,
		`PCWG_MASK_STATUS}; // RQ2 RQ3
	localparam [127:0] RST_ALL = {`PCWG_RST_LATGNT, `PCWG_RST_SUBSYS, `PCWG_RST_CLASS,
		`PCWG_RST_STATUS};

	wire [31:0] word_w [0:3];

	genvar w;
	generate
		for (w = 0; w < 4; w = w + 1) begin : g_word
			pcwg_cfg_word #(
				.LOCAL_MASK(LMASK_ALL[w*32 +: 32]),
				.PCI_MASK(`PCWG_MASK_NONE),
				.RESET_VAL(RST_ALL[w*32 +: 32])
			) u_word (
				.clk_in(ref_clk_in),
				.rst_b_in(rst_sync_q),
				.loc_wr_in(loc_wr_in && loc_sel[w]), // RQ6
				.loc_be_in(loc_be_in),
				.loc_wdata_in(loc_wdata_in),
				.pci_wr_in(cfg_wr_in && cfg_sel[w]), // RQ1
				.pci_be_in(cfg_be_in),
				.pci_wdata_in(cfg_wdata_in),
				.word_out(word_w[w])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read paths
	// ----------------------------------------------------------------
	function [31:0] rd_mux;
		input [3:0] sel;
		input [31:0] w0;
		input [31:0] w1;
		input [31:0] w2;
		input [31:0] w3;
		begin
			rd_mux = ({32{sel[0]}} & w0) | ({32{sel[1]}} & w1)
				| ({32{sel[2]}} & w2) | ({32{sel[3]}} & w3);
		end
	endfunction

	reg [31:0] loc_rdata_q;
	reg [31:0] cfg_rdata_q;
	reg loc_ack_q;
	reg cfg_ack_q;

	always @(posedge ref_clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			loc_rdata_q <= 32'h00000000;
			cfg_rdata_q <= 32'h00000000;
			loc_ack_q <= 1'b0;
			cfg_ack_q <= 1'b0;
		end else begin
			loc_ack_q <= loc_wr_in | loc_rd_in;
			cfg_ack_q <= cfg_wr_in | cfg_rd_in;
			if (loc_rd_in) begin
				loc_rdata_q <= rd_mux(loc_sel, word_w[0], word_w[1], word_w[2], word_w[3]);
			end
			// External reads see the stored value; read-back enables RMW upstream
			if (cfg_rd_in) begin
				cfg_rdata_q <= rd_mux(cfg_sel, word_w[0], word_w[1], word_w[2],
					word_w[3]); // RQ6 RQ5
			end
		end
	end

	assign loc_ack_out = loc_ack_q;
	assign cfg_ack_out = cfg_ack_q;
	assign loc_rdata_out = loc_rdata_q;
	assign cfg_rdata_out = cfg_rdata_q;

	// ----------------------------------------------------------------
	// Field outputs
	// ----------------------------------------------------------------
	assign fast_back_to_back_capable_out = word_w[0][`PCWG_FAST_B2B_CAPABLE_BIT];
	assign user_feature_capable_out = word_w[0][`PCWG_USER_FEATURE_CAPABLE_BIT];
	assign revision_out = word_w[1][31:24];
	assign class_code_out = word_w[1][23:0];
	assign subsystem_vendor_out = word_w[2][15:0];
	assign subsystem_ident_out = word_w[2][31:16];
	assign max_latency_out = word_w[3][7:0];
	assign min_grant_out = word_w[3][15:8];
	assign interrupt_pin_out = word_w[3][23:16];

endmodule

// ==== dv/pcwg_checker.sv ====
/* Assertions on the configuration write guard ports.
 Assumes a bind onto pcwg_guard, one clock, reset active low. */
`timescale 1ns/1ns
module pcwg_checker (
	// Clock and requests
	input wire ref_clk_in,
	input wire rst_b_in,
	input wire loc_wr_in,
	input wire loc_rd_in,
	input wire [31:0] loc_addr_in,
	input wire [3:0] loc_be_in,
	input wire [31:0] loc_wdata_in,
	input wire cfg_wr_in,
	input wire cfg_rd_in,
	input wire [5:0] cfg_dw_in,
	// Answers and fields
	input wire loc_ack_out,
	input wire cfg_ack_out,
	input wire [31:0] cfg_rdata_out,
	input wire fast_back_to_back_capable_out,
	input wire user_feature_capable_out,
	input wire [23:0] class_code_out,
	input wire [7:0] revision_out,
	input wire [15:0] subsystem_vendor_out,
	input wire [15:0] subsystem_ident_out,
	input wire [7:0] max_latency_out,
	input wire [7:0] min_grant_out,
	input wire [7:0] interrupt_pin_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	wire ext_only = cfg_wr_in && !loc_wr_in;
	AST_EXT_CLASS: assert property (ext_only |=> $stable({revision_out, class_code_out}))
		else $error("external write changed class or revision");
	AST_EXT_STATUS: assert property (ext_only |=>
		$stable({fast_back_to_back_capable_out, user_feature_capable_out}))
		else $error("external write changed status capability bits");
	AST_EXT_TAIL: assert property (ext_only |=> $stable({subsystem_ident_out,
		subsystem_vendor_out, interrupt_pin_out, min_grant_out, max_latency_out}))
		else $error("external write changed subsystem or latency fields");
	// Lane 2 of the class word is not guarded here and stores nothing
	AST_BOTH_WR: assert property (cfg_wr_in && loc_wr_in && loc_addr_in == 32'hFFFED008 &&
		loc_be_in == 4'hF |=> {revision_out, class_code_out}
		== ($past(loc_wdata_in) & 32'hFF00FFFF))
		else $error("concurrent write did not keep local data");
	AST_LOC_WR: assert property (loc_wr_in && loc_addr_in == 32'hFFFED02C &&
		loc_be_in == 4'hF |=> {subsystem_ident_out, subsystem_vendor_out} == $past(loc_wdata_in))
		else $error("local write did not update subsystem fields");
	AST_LOC_ACK: assert property (loc_wr_in || loc_rd_in |=> loc_ack_out)
		else $error("local access not acknowledged");
	AST_ACK_IDLE: assert property (!(loc_wr_in || loc_rd_in) |=> !loc_ack_out)
		else $error("local ack without a request");
	AST_CFG_ACK: assert property (cfg_wr_in || cfg_rd_in |=> cfg_ack_out)
		else $error("configuration access not acknowledged");
	AST_CFG_RD: assert property (cfg_rd_in && cfg_dw_in == 6'h0F && !loc_wr_in |=>
		cfg_rdata_out == {8'h00, interrupt_pin_out, min_grant_out, max_latency_out})
		else $error("external read differs from stored fields");
	cover property (cfg_wr_in && loc_wr_in);
	cover property (ext_only);
	cover property (cfg_rd_in);
endmodule

// ==== dv/pcwg_cfg_master.sv ====
/* Model of an external PCI master issuing configuration cycles.
 Assumes the guard answers with a registered ack one cycle after the request. */
`timescale 1ns/1ns
module pcwg_cfg_master (
	// Clock
	input wire clk_in,
	// Request
	output logic wr_out = 1'h0,
	output logic rd_out = 1'h0,
	output logic [5:0] dw_out = 6'h0,
	output logic [3:0] be_out = 4'h0,
	output logic [31:0] wdata_out = 32'h0,
	// Answer
	input wire ack_in,
	input wire [31:0] rdata_in
);
	task req(input logic w, input logic [5:0] dw, input logic [31:0] d, output logic [31:0] r);
		@(negedge clk_in);
		wr_out = w;
		rd_out = !w;
		dw_out = dw;
		be_out = 4'hF;
		wdata_out = d;
		@(negedge clk_in);
		wr_out = 1'h0;
		rd_out = 1'h0;
		// Released data never keeps the last word
		wdata_out = ~d;
		r = ack_in ? rdata_in : 'x;
	endtask
	// Guarded positions carry back what was read
	task rmw(input logic [5:0] dw, input logic [31:0] m, input logic [31:0] d);
		logic [31:0] r;
		req(1'h0, dw, 32'h0, r);
		req(1'h1, dw, (r & m) | (d & ~m), r);
	endtask
endmodule

// ==== dv/tb.sv ====
/* Self-checking bench for the configuration write guard.
 Assumes pcwg_guard, the master model and the checker are compiled first. */
`timescale 1ns/1ns
`include "pcwg_regs.vh"
module tb;
	reg clk = 1'h0;
	reg rst_b = 1'h0;
	reg loc_wr = 1'h0;
	reg loc_rd = 1'h0;
	reg [31:0] loc_addr = 32'h0;
	reg [3:0] loc_be = 4'h0;
	reg [3:0] be_sel = 4'hF;
	reg [31:0] loc_wdata = 32'h0;
	wire loc_ack, cfg_wr, cfg_rd, cfg_ack;
	wire [5:0] cfg_dw;
	wire [3:0] cfg_be;
	wire [31:0] loc_rdata, cfg_wdata, cfg_rdata;
	logic [31:0] q, q2, a, e[4], m[4];
	logic [5:0] dw[4];
	int miscompares = 0, compares = 0, i, j, k;
	localparam logic [31:0] PAT = 32'h96C35AA5;
	always #10 clk = ~clk;
	pcwg_guard i_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .loc_wr_in(loc_wr), .loc_rd_in(loc_rd),
		.loc_addr_in(loc_addr), .loc_be_in(loc_be), .loc_wdata_in(loc_wdata),
		.loc_ack_out(loc_ack), .loc_rdata_out(loc_rdata), .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd),
		.cfg_dw_in(cfg_dw), .cfg_be_in(cfg_be), .cfg_wdata_in(cfg_wdata), .cfg_ack_out(cfg_ack),
		.cfg_rdata_out(cfg_rdata), .fast_back_to_back_capable_out(), .user_feature_capable_out(),
		.class_code_out(), .revision_out(), .subsystem_vendor_out(), .subsystem_ident_out(),
		.max_latency_out(), .min_grant_out(), .interrupt_pin_out());
	pcwg_cfg_master i_mst (.clk_in(clk), .wr_out(cfg_wr), .rd_out(cfg_rd), .dw_out(cfg_dw),
		.be_out(cfg_be), .wdata_out(cfg_wdata), .ack_in(cfg_ack), .rdata_in(cfg_rdata));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task loc(input logic w, input logic [5:0] d6, input logic [31:0] d, output logic [31:0] r);
		@(negedge clk);
		loc_wr = w;
		loc_rd = !w;
		loc_addr = `PCWG_CFG_BASE + {24'h0, d6, 2'h0};
		loc_be = be_sel;
		loc_wdata = d;
		@(negedge clk);
		loc_wr = 1'h0;
		loc_rd = 1'h0;
		r = loc_ack ? loc_rdata : 'x;
	endtask
	task end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		dw = '{`PCWG_DW_STATUS, `PCWG_DW_CLASS, `PCWG_DW_SUBSYS, `PCWG_DW_LATGNT};
		m = '{`PCWG_MASK_STATUS, `PCWG_MASK_CLASS, `PCWG_MASK_SUBSYS, `PCWG_MASK_LATGNT};
		repeat (2) @(negedge clk);
		rst_b = 1'h1;
		// Synchroniser needs its edges before the first request
		repeat (3) @(negedge clk);
		for (i = 0; i < 4; i++) begin
			e[i] = PAT & m[i];
			i_mst.req(1'h0, dw[i], 32'h0, q);
			chk(q, 32'h0);
			loc(1'h1, dw[i], PAT, q);
			i_mst.req(1'h1, dw[i], ~PAT, q);
			i_mst.req(1'h0, dw[i], 32'h0, q);
			chk(q, e[i]);
			i_mst.rmw(dw[i], m[i], 32'h5A5A5A5A);
			loc(1'h0, dw[i], 32'h0, q);
			chk(q, e[i]);
		end
		$display("test local and external writes done");
		for (i = 0; i < 4; i++)
			for (j = 0; j < 2; j++) begin
				k = (i + j) % 4;
				a = PAT ^ {8{4'(2 * i + j + 1)}};
				e[k] = a & m[k];
				fork
					loc(1'h1, dw[k], a, q);
					i_mst.req(1'h1, dw[i], 32'hC3C3C3C3 ^ a, q2);
				join
				i_mst.req(1'h0, dw[i], 32'h0, q);
				chk(q, e[i]);
				loc(1'h0, dw[k], 32'h0, q);
				chk(q, e[k]);
			end
		// Partial enables: only lanes 0 and 2 of the subsystem word move
		be_sel = 4'h5;
		loc(1'h1, dw[2], 32'hFFFFFFFF, q);
		be_sel = 4'hF;
		loc(1'h0, dw[2], 32'h0, q);
		chk(q, ((e[2] & 32'hFF00FF00) | 32'h00FF00FF) & m[2]);
		loc(1'h1, 6'h10, PAT, q);
		loc(1'h0, 6'h10, 32'h0, q);
		chk(q, 32'h0);
		$display("test concurrent writes done");
		end_of_test;
	end
	initial begin
		#20000;
		miscompares++;
		end_of_test;
	end
endmodule
bind pcwg_guard pcwg_checker i_chk (.*);
